// *** logic/mcx_pkg.sv ***
package mcx_pkg;

    // -------------------------------------------------------------------
    // instruction encoding
    // -------------------------------------------------------------------
    // register-register group lives in op4 0..2, selected by op6
    localparam logic [3:0] OP4_REG_LAST = 4'h2;
    localparam logic [5:0] OP6_ADD = 6'h01;
    localparam logic [5:0] OP6_ADD_CARRY = 6'h02;
    localparam logic [5:0] OP6_DIFF = 6'h03;
    localparam logic [5:0] OP6_DIFF_BORROW = 6'h04;
    localparam logic [5:0] OP6_CONJ = 6'h05;
    localparam logic [5:0] OP6_DISJ = 6'h06;
    localparam logic [5:0] OP6_XDISJ = 6'h07;
    localparam logic [5:0] OP6_COMPARE = 6'h08;
    localparam logic [5:0] OP6_COMPARE_CARRY = 6'h09;
    localparam logic [5:0] OP6_EQUAL_SKIP = 6'h0A;
    localparam logic [5:0] OP6_REG_COPY = 6'h0B;
    localparam logic [3:0] OP4_DIFF_IMM = 4'h3;
    localparam logic [3:0] OP4_DIFF_IMM_BORROW = 4'h4;
    localparam logic [3:0] OP4_CONJ_IMM = 4'h5;
    localparam logic [3:0] OP4_DISJ_IMM = 4'h6;
    localparam logic [3:0] OP4_COMPARE_IMM = 4'h7;
    localparam logic [3:0] OP4_IMM_LOAD = 4'h8;
    localparam logic [3:0] OP4_MASK_CLEAR = 4'h9;
    localparam logic [3:0] OP4_REL_JUMP = 4'hA;
    localparam logic [3:0] OP4_REL_INVOKE = 4'hB;
    localparam logic [3:0] OP4_BRANCH = 4'hC;
    localparam logic [3:0] OP4_BIT_SKIP = 4'hD;
    localparam logic [3:0] OP4_PORT_XFER = 4'hE;
    localparam logic [3:0] OP4_MISC = 4'hF;
    localparam logic [3:0] MISC_SUBR_BACK = 4'h0;
    localparam logic [3:0] MISC_IRQ_BACK = 4'h1;
    localparam logic [3:0] MISC_IND_FETCH = 4'h2;
    localparam logic [3:0] MISC_IND_SAVE = 4'h3;
    localparam logic [7:0] MASK_ALL_ONES = 8'hFF;

    // -------------------------------------------------------------------
    // flag byte layout
    // -------------------------------------------------------------------
    localparam int FLG_C = 0;
    localparam int FLG_Z = 1;
    localparam int FLG_N = 2;
    localparam int FLG_V = 3;
    localparam int FLG_S = 4;
    localparam int FLG_H = 5;
    localparam int FLG_T = 6;
    localparam int FLG_I = 7;
    localparam logic [7:0] FLAG_RST = 8'h00;

    // -------------------------------------------------------------------
    // extra cycles beyond the first
    // -------------------------------------------------------------------
    localparam logic [1:0] EXTRA_SKIP = 2'h1;
    localparam logic [1:0] EXTRA_BRANCH = 2'h1;
    localparam logic [1:0] EXTRA_JUMP = 2'h1;
    localparam logic [1:0] EXTRA_INVOKE = 2'h2;
    localparam logic [1:0] EXTRA_BACK = 2'h3;
    localparam logic [1:0] EXTRA_MEM = 2'h1;

    // -------------------------------------------------------------------
    // register bus map
    // -------------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_PC = 8'h08;
    localparam logic RUN_RST = 1'b1;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [2:0] {
        ALU_PASS,
        ALU_ADD,
        ALU_SUB,
        ALU_AND,
        ALU_OR,
        ALU_XOR
    } mcx_alu_e;

endpackage

// *** logic/mcx_core.sv ***
// The placing of the registers and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/10ps
// Operation
// - add registers, optional carry, flags, one clock
// - register subtract, optional borrow, flags, one clock
// - immediate subtract, optional borrow, flags, one clock
// - and/or/xor update only Z N V S
// - set bits ORs mask, Z N V S
// - clear bits ANDs with FFh minus mask
// - test ANDs register with itself, flags only
// - compares set flags, write no register
// - equal skip advances by two, two clocks
// - skip on working register bit low/high
// - skip on io register bit low/high
// - flag branch target pc plus k plus one
// - signed branches test N xor V
// - unsigned branches test carry flag
// - I H T V branches, both senses
module mcx_core import mcx_pkg::*; #(
    parameter int PCW = 12,
    parameter int STACK_DEPTH = 4
) (
    input wire logic core_clk_i, // core clock
    input wire logic arst_n_i, // async reset, active low
    input wire logic ce_i, // clock enable, freezes all state
    output logic [PCW-1:0] imem_addr_o, // program word address
    input wire logic [15:0] imem_data_i, // program word, same cycle
    output logic [5:0] io_raddr_o, // io read address, from the current word
    input wire logic [7:0] io_rdata_i, // io read data
    output logic [5:0] io_waddr_o, // io write address
    output logic [7:0] io_wdata_o, // io write data
    output logic io_we_o, // io write strobe
    output logic [15:0] dmem_addr_o, // data address from pointer pair
    output logic [7:0] dmem_wdata_o, // data write value
    output logic dmem_we_o, // data write strobe
    output logic dmem_re_o, // data read strobe
    input wire logic [7:0] dmem_rdata_i, // data read value
    input wire logic [7:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write strobes
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [7:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read valid
    input wire logic s_axi_rready // read ready
);

    localparam int SPW = $clog2(STACK_DEPTH);

    logic [PCW-1:0] pc_q;
    logic [PCW-1:0] pc_d;
    logic [7:0] flag_q;
    logic [7:0] flag_d;
    logic [1:0] extra_q;
    logic [1:0] extra_d;
    logic [7:0] rf_q [32];
    logic [PCW-1:0] stk_q [STACK_DEPTH];
    logic [SPW-1:0] sp_q;
    logic run_q;
    logic ld_pend_q;
    logic [4:0] ld_idx_q;
    logic exec_en;
    logic ex_we;
    logic [4:0] ex_idx;
    logic [7:0] ex_val;
    logic push;
    logic pop;
    logic out_we;
    logic mem_rd;
    logic mem_wr;
    logic [15:0] ins;
    logic [3:0] op4;
    logic [4:0] d_reg;
    logic [4:0] s_reg;
    logic [4:0] di_reg;
    logic [7:0] k8;
    logic [15:0] pc16;
    logic [15:0] next16;
    logic [PCW-1:0] ret_addr;
    logic [15:0] skip16;
    logic [15:0] jump16;
    logic [15:0] br16;

    assign ins = imem_data_i;
    assign op4 = ins[15:12];
    assign d_reg = ins[9:5];
    assign s_reg = ins[4:0];
    assign di_reg = {1'b1, ins[11:8]};
    assign k8 = ins[7:0];
    assign pc16 = 16'(pc_q);
    assign next16 = pc16 + 16'h0001;
    assign skip16 = next16 + 16'h0001;
    assign jump16 = next16 + {{4{ins[11]}}, ins[11:0]};
    assign br16 = next16 + {{8{k8[7]}}, k8};
    assign ret_addr = stk_q[sp_q - SPW'(1)];
    assign exec_en = run_q && (extra_q == 2'h0);
    assign imem_addr_o = pc_q;
    // io read address is taken from the word being executed so that
    // a port read still finishes in a single clock
    assign io_raddr_o = (op4 == OP4_BIT_SKIP) ? ins[8:3] : ins[5:0];

    function automatic logic [7:0] arith_flags(input logic [7:0] old, input logic [7:0] a,
        input logic [7:0] b, input logic [7:0] r, input logic sub);
        logic [7:0] f;
        logic c;
        logic h;
        logic v;
        f = old;
        if (sub) begin
            c = (~a[7] & b[7]) | (b[7] & r[7]) | (r[7] & ~a[7]);
            h = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
            v = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
        end else begin
            c = (a[7] & b[7]) | (b[7] & ~r[7]) | (~r[7] & a[7]);
            h = (a[3] & b[3]) | (b[3] & ~r[3]) | (~r[3] & a[3]);
            v = (a[7] & b[7] & ~r[7]) | (~a[7] & ~b[7] & r[7]);
        end
        f[FLG_C] = c;
        f[FLG_Z] = (r == 8'h00);
        f[FLG_N] = r[7];
        f[FLG_V] = v;
        f[FLG_S] = r[7] ^ v;
        f[FLG_H] = h;
        return f;
    endfunction

    // carry and half-carry are left alone by the logic group
    function automatic logic [7:0] logic_flags(input logic [7:0] old, input logic [7:0] r);
        logic [7:0] f;
        f = old;
        f[FLG_Z] = (r == 8'h00);
        f[FLG_N] = r[7];
        f[FLG_V] = 1'b0;
        f[FLG_S] = r[7];
        return f;
    endfunction

    // -------------------------------------------------------------------
    // decode and execute
    // -------------------------------------------------------------------
    always_comb begin
        mcx_alu_e mode;
        logic [7:0] a;
        logic [7:0] b;
        logic cin;
        logic upd;
        logic [7:0] res;
        logic hit;
        mode = ALU_PASS;
        a = rf_q[d_reg];
        b = rf_q[s_reg];
        cin = 1'b0;
        upd = 1'b0;
        res = 8'h00;
        hit = 1'b0;
        ex_we = 1'b0;
        ex_idx = d_reg;
        ex_val = 8'h00;
        flag_d = flag_q;
        pc_d = next16[PCW-1:0];
        extra_d = 2'h0;
        push = 1'b0;
        pop = 1'b0;
        out_we = 1'b0;
        mem_rd = 1'b0;
        mem_wr = 1'b0;
        if (op4 <= OP4_REG_LAST) begin
            case (ins[15:10])
                OP6_ADD, OP6_ADD_CARRY: begin
                    mode = ALU_ADD;
                    cin = (ins[15:10] == OP6_ADD_CARRY) & flag_q[FLG_C];
                    ex_we = 1'b1;
                end
                OP6_DIFF, OP6_DIFF_BORROW: begin
                    mode = ALU_SUB;
                    cin = (ins[15:10] == OP6_DIFF_BORROW) & flag_q[FLG_C];
                    ex_we = 1'b1;
                end
                OP6_CONJ: begin
                    mode = ALU_AND;
                    ex_we = 1'b1;
                end
                OP6_DISJ: begin
                    mode = ALU_OR;
                    ex_we = 1'b1;
                end
                OP6_XDISJ: begin
                    mode = ALU_XOR;
                    ex_we = 1'b1;
                end
                OP6_COMPARE, OP6_COMPARE_CARRY: begin
                    mode = ALU_SUB;
                    cin = (ins[15:10] == OP6_COMPARE_CARRY) & flag_q[FLG_C];
                end
                OP6_EQUAL_SKIP: begin
                    if (a == b) begin
                        pc_d = skip16[PCW-1:0];
                        extra_d = EXTRA_SKIP;
                    end
                end
                OP6_REG_COPY: begin
                    ex_we = 1'b1;
                    ex_val = b;
                end
                default: begin
                end
            endcase
        end else begin
            case (op4)
                OP4_DIFF_IMM, OP4_DIFF_IMM_BORROW, OP4_COMPARE_IMM: begin
                    mode = ALU_SUB;
                    a = rf_q[di_reg];
                    b = k8;
                    cin = (op4 == OP4_DIFF_IMM_BORROW) & flag_q[FLG_C];
                    ex_we = (op4 != OP4_COMPARE_IMM);
                    ex_idx = di_reg;
                end
                OP4_CONJ_IMM, OP4_DISJ_IMM, OP4_MASK_CLEAR: begin
                    mode = (op4 == OP4_DISJ_IMM) ? ALU_OR : ALU_AND;
                    a = rf_q[di_reg];
                    b = (op4 == OP4_MASK_CLEAR) ? MASK_ALL_ONES - k8 : k8;
                    ex_we = 1'b1;
                    ex_idx = di_reg;
                end
                OP4_IMM_LOAD: begin
                    ex_we = 1'b1;
                    ex_idx = di_reg;
                    ex_val = k8;
                end
                OP4_REL_JUMP, OP4_REL_INVOKE: begin
                    pc_d = jump16[PCW-1:0];
                    push = (op4 == OP4_REL_INVOKE);
                    extra_d = push ? EXTRA_INVOKE : EXTRA_JUMP;
                end
                OP4_BRANCH: begin
                    // signed and unsigned forms are the S and C flag selects
                    if (flag_q[ins[10:8]] == ins[11]) begin
                        pc_d = br16[PCW-1:0];
                        extra_d = EXTRA_BRANCH;
                    end
                end
                OP4_BIT_SKIP: begin
                    if (ins[11]) begin
                        hit = (io_rdata_i[ins[2:0]] == ins[10]);
                    end else begin
                        hit = (rf_q[ins[7:3]][ins[2:0]] == ins[10]);
                    end
                    if (hit) begin
                        pc_d = skip16[PCW-1:0];
                        extra_d = EXTRA_SKIP;
                    end
                end
                OP4_PORT_XFER: begin
                    ex_idx = ins[10:6];
                    ex_we = ~ins[11];
                    ex_val = io_rdata_i;
                    out_we = ins[11];
                end
                OP4_MISC: begin
                    case (ins[11:8])
                        MISC_SUBR_BACK, MISC_IRQ_BACK: begin
                            pop = 1'b1;
                            pc_d = ret_addr;
                            extra_d = EXTRA_BACK;
                            if (ins[11:8] == MISC_IRQ_BACK) begin
                                flag_d[FLG_I] = 1'b1;
                            end
                        end
                        MISC_IND_FETCH: begin
                            mem_rd = 1'b1;
                            extra_d = EXTRA_MEM;
                        end
                        MISC_IND_SAVE: begin
                            mem_wr = 1'b1;
                            extra_d = EXTRA_MEM;
                        end
                        default: begin
                        end
                    endcase
                end
                default: begin
                end
            endcase
        end
        case (mode)
            ALU_ADD: res = a + b + {7'h00, cin};
            ALU_SUB: res = a - b - {7'h00, cin};
            ALU_AND: res = a & b;
            ALU_OR: res = a | b;
            ALU_XOR: res = a ^ b;
            default: res = 8'h00;
        endcase
        upd = (mode != ALU_PASS);
        if (mode == ALU_ADD || mode == ALU_SUB) begin
            flag_d = arith_flags(flag_q, a, b, res, mode == ALU_SUB);
        end else if (upd) begin
            flag_d = logic_flags(flag_q, res);
        end
        if (upd) begin
            ex_val = res;
        end
    end

    // -------------------------------------------------------------------
    // sequencing
    // -------------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pc_q <= '0;
            flag_q <= FLAG_RST;
            extra_q <= 2'h0;
        end else if (ce_i) begin
            if (exec_en) begin
                pc_q <= pc_d;
                flag_q <= flag_d;
                extra_q <= extra_d;
            end else if (extra_q != 2'h0) begin
                extra_q <= extra_q - 2'h1;
            end
        end
    end

    // a load lands in the stall cycle, so it can never collide with an execute write
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            for (int i = 0; i < 32; i++) begin
                rf_q[i] <= 8'h00;
            end
        end else if (ce_i) begin
            if (exec_en && ex_we) begin
                rf_q[ex_idx] <= ex_val;
            end else if (ld_pend_q) begin
                rf_q[ld_idx_q] <= dmem_rdata_i;
            end
        end
    end

    // circular stack: overflow silently overwrites the oldest entry
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sp_q <= '0;
            for (int i = 0; i < STACK_DEPTH; i++) begin
                stk_q[i] <= '0;
            end
        end else if (ce_i && exec_en) begin
            if (push) begin
                stk_q[sp_q] <= next16[PCW-1:0];
                sp_q <= sp_q + SPW'(1);
            end else if (pop) begin
                sp_q <= sp_q - SPW'(1);
            end
        end
    end

    // -------------------------------------------------------------------
    // io and data memory
    // -------------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            io_waddr_o <= 6'h00;
            io_wdata_o <= 8'h00;
            io_we_o <= 1'b0;
            dmem_addr_o <= 16'h0000;
            dmem_wdata_o <= 8'h00;
            dmem_we_o <= 1'b0;
            dmem_re_o <= 1'b0;
            ld_pend_q <= 1'b0;
            ld_idx_q <= 5'h00;
        end else if (ce_i) begin
            io_we_o <= exec_en && out_we;
            dmem_we_o <= exec_en && mem_wr;
            dmem_re_o <= exec_en && mem_rd;
            ld_pend_q <= exec_en && mem_rd;
            if (exec_en && out_we) begin
                io_waddr_o <= ins[5:0];
                io_wdata_o <= rf_q[ins[10:6]];
            end
            if (exec_en && (mem_rd || mem_wr)) begin
                dmem_addr_o <= {rf_q[31], rf_q[30]};
                dmem_wdata_o <= rf_q[s_reg];
                ld_idx_q <= s_reg;
            end
        end
    end

    // -------------------------------------------------------------------
    // register bus slave
    // -------------------------------------------------------------------
    logic aw_have_q;
    logic w_have_q;
    logic aw_have_d;
    logic w_have_d;
    logic rvalid_d;
    logic wr_fire;
    logic bvalid_d;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;

    assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
    assign aw_have_d = wr_fire ? 1'b0 : (aw_have_q | (s_axi_awvalid & s_axi_awready));
    assign w_have_d = wr_fire ? 1'b0 : (w_have_q | (s_axi_wvalid & s_axi_wready));
    assign rvalid_d = (s_axi_arvalid & s_axi_arready) | (s_axi_rvalid & ~s_axi_rready);
    // readies stay low while a response waits, so no write queues behind it
    assign bvalid_d = wr_fire | (s_axi_bvalid & ~s_axi_bready);

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            run_q <= RUN_RST;
        end else if (ce_i) begin
            aw_have_q <= aw_have_d;
            w_have_q <= w_have_d;
            s_axi_awready <= ~aw_have_d & ~bvalid_d;
            s_axi_wready <= ~w_have_d & ~bvalid_d;
            if (s_axi_awvalid && s_axi_awready) begin
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= RESP_OKAY;
                if (awaddr_q[7:2] == ADDR_CTRL[7:2]) begin
                    if (wstrb_q[0]) begin
                        run_q <= wdata_q[0];
                    end
                end else if (awaddr_q[7:2] != ADDR_STATUS[7:2] &&
                             awaddr_q[7:2] != ADDR_PC[7:2]) begin
                    s_axi_bresp <= RESP_SLVERR;
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else if (ce_i) begin
            s_axi_rvalid <= rvalid_d;
            s_axi_arready <= ~rvalid_d;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rresp <= RESP_OKAY;
                if (s_axi_araddr[7:2] == ADDR_CTRL[7:2]) begin
                    s_axi_rdata <= {31'h0000_0000, run_q};
                end else if (s_axi_araddr[7:2] == ADDR_STATUS[7:2]) begin
                    s_axi_rdata <= {21'h00_0000, extra_q, ld_pend_q, flag_q};
                end else if (s_axi_araddr[7:2] == ADDR_PC[7:2]) begin
                    s_axi_rdata <= 32'(pc_q);
                end else begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= RESP_SLVERR;
                end
            end
        end
    end

endmodule

// *** dv/mcx_pmem.sv ***
`timescale 1ns/10ps
module mcx_pmem #(parameter int PCW = 12) (
    input wire logic [PCW-1:0] addr_i, // word address
    output logic [15:0] data_o // instruction word
);
    logic [15:0] mem [16];
    // beyond the loaded words a jump onto itself parks the core
    assign data_o = (addr_i < 16) ? mem[addr_i[3:0]] : 16'hAFFF;
endmodule

// *** dv/mcx_core_monitor.sv ***
`timescale 1ns/10ps
module mcx_core_monitor import mcx_pkg::*; (
    input wire logic core_clk_i, // clk
    input wire logic arst_n_i, // rst
    input wire logic [7:0] s_axi_araddr, // ar
    input wire logic s_axi_arvalid, // ar
    input wire logic s_axi_arready, // ar
    input wire logic [31:0] s_axi_rdata, // r
    input wire logic [1:0] s_axi_rresp, // r
    input wire logic s_axi_rvalid, // r
    input wire logic s_axi_rready, // r
    input wire logic s_axi_awvalid, // aw
    input wire logic s_axi_awready, // aw
    input wire logic s_axi_wvalid, // w
    input wire logic s_axi_wready, // w
    input wire logic s_axi_bvalid, // b
    input wire logic s_axi_bready, // b
    input wire logic dmem_re_o // load strobe
);
    // ----------------------------------------------------------------
    // bus and load timing
    // ----------------------------------------------------------------
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!arst_n_i);
    sequence ar_take; s_axi_arvalid && s_axi_arready; endsequence
    sequence wr_take; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
    chk_read_answer: assert property (ar_take |=> s_axi_rvalid)
        else $error("read answer missing");
    chk_write_answer: assert property (wr_take |-> ##2 s_axi_bvalid)
        else $error("write answer missing");
    chk_read_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read data not released");
    chk_write_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answer not released");
    chk_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while busy");
    chk_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("write address taken while busy");
    chk_unmapped_err: assert property ((ar_take and (s_axi_araddr > ADDR_PC)) |=>
        s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read accepted");
    chk_load_pulse: assert property (dmem_re_o |=> !dmem_re_o)
        else $error("load strobe too long");
endmodule
bind mcx_core mcx_core_monitor mcx_core_monitor_inst (.core_clk_i, .arst_n_i, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
    .s_axi_bready, .dmem_re_o);

// *** dv/mcx_core_tb.sv ***
`timescale 1ns/10ps
module mcx_core_tb;
    import mcx_pkg::*;
    logic core_clk_i = 1'b0, arst_n_i = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, io_v = 8'h00, dm_v = 8'h00, a, b;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, io_we_o, dmem_re_o;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [15:0] imem_data_i, dmem_addr_o;
    logic [11:0] imem_addr_o;
    logic [5:0] io_waddr_o;
    logic [7:0] io_wdata_o;
    logic [33:0] io_q[$], rsp_q[$];
    int error_cnt = 0, num_checks = 0;
    always #50 core_clk_i = ~core_clk_i;
    mcx_pmem #(.PCW(12)) mcx_pmem_inst (.addr_i(imem_addr_o), .data_o(imem_data_i));
    mcx_core mcx_core_inst (.core_clk_i, .arst_n_i, .ce_i(1'b1), .imem_addr_o, .imem_data_i,
        .io_raddr_o(), .io_rdata_i(io_v), .io_waddr_o, .io_wdata_o, .io_we_o, .dmem_addr_o,
        .dmem_wdata_o(), .dmem_we_o(), .dmem_re_o, .dmem_rdata_i(dm_v), .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    // ----------------------------------------------------------------
    // checking and bus helpers
    // ----------------------------------------------------------------
    task automatic cmp(input logic [33:0] got, input logic [33:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic bus(input logic wr, input logic [7:0] ad, input logic [31:0] d,
        input logic [33:0] e);
        int n;
        n = 0;
        rsp_q.push_back(e);
        s_axi_awaddr <= ad;
        s_axi_araddr <= ad;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{wr}};
        {s_axi_arvalid, s_axi_rready} <= {2{!wr}};
        do begin
            @(posedge core_clk_i);
            n++;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_bready && s_axi_bvalid) s_axi_bready <= 1'b0;
            if (s_axi_rready && s_axi_rvalid) s_axi_rready <= 1'b0;
        end while (n < 60 && (s_axi_bready || s_axi_rready));
        if (n >= 60) begin
            error_cnt++;
            wrap_up;
        end
    endtask
    // io writes and bus answers are matched against the oldest note
    always @(posedge core_clk_i) begin
        if (io_we_o === 1'b1)
            cmp({26'(io_waddr_o), io_wdata_o}, io_q.size() > 0 ? io_q.pop_front() : '1);
        if (dmem_re_o === 1'b1) cmp(34'(dmem_addr_o), 34'h0);
        if (s_axi_rvalid === 1'b1 && s_axi_rready)
            cmp({s_axi_rresp, s_axi_rdata}, rsp_q.pop_front());
        if (s_axi_bvalid === 1'b1 && s_axi_bready) cmp({s_axi_bresp, 32'h0}, rsp_q.pop_front());
    end
    initial begin
        repeat (3000) @(posedge core_clk_i);
        error_cnt++;
        wrap_up;
    end
    initial begin
        void'($urandom(32'he4d1da90));
        a = $urandom;
        b = $urandom;
        io_v = $urandom;
        dm_v = $urandom;
        mcx_pmem_inst.mem = '{{8'h80, a}, {8'h81, b}, 16'h0611, 16'hEC01, 16'h0E11, 16'h1E11,
            16'hEC02, 16'h2A10, 16'hEC03, 16'hF213, 16'hDC28, 16'hECC4, 16'h2231, 16'hC901,
            16'hEC05, 16'hEC46};
        io_q.push_back({26'd1, a + b});
        io_q.push_back({26'd2, a ^ b});
        if (!io_v[0]) io_q.push_back({26'd4, dm_v});
        io_q.push_back({26'd6, b});
        repeat (6) @(posedge core_clk_i);
        arst_n_i <= 1'b1;
        for (int n = 0; n < 200 && io_q.size() > 0; n++) @(posedge core_clk_i);
        bus(1'b1, ADDR_CTRL, 32'h0, {RESP_OKAY, 32'h0});
        bus(1'b0, ADDR_CTRL, 32'h0, {RESP_OKAY, 32'h0});
        bus(1'b0, ADDR_STATUS, 32'h0, {RESP_OKAY, 32'h2});
        bus(1'b0, ADDR_PC, 32'h0, {RESP_OKAY, 32'h10});
        bus(1'b0, 8'h0C, 32'h0, {RESP_SLVERR, 32'h0});
        bus(1'b1, 8'h0C, 32'h1, {RESP_SLVERR, 32'h0});
        cmp(34'(io_q.size()), 34'h0);
        wrap_up;
    end
endmodule
